// *** hw/amcs_defines.svh ***
// Constants and behaviour list of the amplifier module control supervisor
// Behaviour
// [RL1] Standby request high enters standby mode
// [RL2] Standby input defaults low, normal operation
// [RL3] Standby: amp and analog supplies off
// [RL4] Front end waits 3 s between mode changes
// [RL5] Front end lowers control load before standby
// [RL6] Mute request shuts down amplifier only
// [RL7] Mute input defaults low, amplifier runs
// [RL8] Mute keeps every supply running
// [RL9] One low clip pulse per clipping cycle
// [RL10] Thermal warning holds clip flag low
// [RL11] Clip flag only pulls low or releases
// [RL12] Destructive overload shuts down, fault flag low
// [RL13] Fault flag on amp, supply, thermal faults
// [RL14] Resume after delay; thermal waits for recovery
// [RL15] Primary side events never reach fault flag
// [RL16] Fault flag is open collector, pulls low
// [RL17] Control supply overcurrent cycles all aux supplies
// [RL18] Analog supply overcurrent cycles all aux supplies
// [RL19] Hanger rail supply stays on in standby
// [RL20] Power-up samples inputs, starts accordingly
// [RL21] Self-check error reboots after short delay
// [RL22] Control inputs synchronised and debounced
`ifndef AMCS_DEFINES_SVH
`define AMCS_DEFINES_SVH
`define AMCS_CLK_MHZ 100
`define AMCS_DEBOUNCE_US 1000
`define AMCS_DEBOUNCE_CYC (`AMCS_DEBOUNCE_US * `AMCS_CLK_MHZ)
`define AMCS_RESTART_MS 100
`define AMCS_RESTART_CYC (`AMCS_RESTART_MS * 1000 * `AMCS_CLK_MHZ)
`define AMCS_REBOOT_MS 500
`define AMCS_REBOOT_CYC (`AMCS_REBOOT_MS * 1000 * `AMCS_CLK_MHZ)
`define AMCS_CNT_W 32
`endif

// *** hw/amcs_pkg.sv ***
// Types of the amplifier module control supervisor
package amcs_pkg;
	typedef enum logic [2:0] {
		AMCS_BOOT,
		AMCS_REBOOT,
		AMCS_RUN,
		AMCS_STANDBY,
		AMCS_AMP_FAULT,
		AMCS_AUX_FAULT,
		AMCS_THERM_FAULT
	} amcs_state_type;
endpackage

// *** hw/amcs_supervisor.sv ***
// Control and status supervisor of the amplifier module
`timescale 1ns/10ps
`include "amcs_defines.svh"
module amcs_supervisor #(
	parameter int DEBOUNCE_CYC = `AMCS_DEBOUNCE_CYC,
	parameter int RESTART_CYC = `AMCS_RESTART_CYC,
	parameter int REBOOT_CYC = `AMCS_REBOOT_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_standby_request,
	input wire logic i_amplifier_mute_request,
	input wire logic i_selfcheck_done,
	input wire logic i_selfcheck_error,
	input wire logic i_pwm_cycle,
	input wire logic i_clip_event,
	input wire logic i_thermal_warning,
	input wire logic i_amp_overcurrent,
	input wire logic i_control_supply_oc,
	input wire logic i_analog_supply_oc,
	input wire logic i_module_overtemp,
	input wire logic i_thermal_recovered,
	input wire logic i_primary_fault,
	output logic o_amp_enable,
	output logic o_positive_analog_supply_en,
	output logic o_negative_analog_supply_en,
	output logic o_control_supply_out_en,
	output logic o_control_supply_low_power,
	output logic o_hanger_rail_supply_en,
	output logic o_clip_flag_out,
	output logic o_clip_flag_oe,
	output logic o_fault_flag_out,
	output logic o_fault_flag_oe,
	output amcs_pkg::amcs_state_type o_state
);
	localparam logic [`AMCS_CNT_W-1:0] DB_MAX = `AMCS_CNT_W'(DEBOUNCE_CYC);
	localparam logic [`AMCS_CNT_W-1:0] RS_MAX = `AMCS_CNT_W'(RESTART_CYC);
	localparam logic [`AMCS_CNT_W-1:0] RB_MAX = `AMCS_CNT_W'(REBOOT_CYC);

	// Synchronisers and debouncers; pull-downs modelled by low reset values
	logic [1:0] sb_sync_reg, sb_sync_next;
	logic [1:0] mu_sync_reg, mu_sync_next;
	logic sb_db_reg, sb_db_next;
	logic mu_db_reg, mu_db_next;
	logic [`AMCS_CNT_W-1:0] sb_cnt_reg, sb_cnt_next;
	logic [`AMCS_CNT_W-1:0] mu_cnt_reg, mu_cnt_next;

	always_comb begin
		sb_sync_next = {sb_sync_reg[0], i_standby_request}; // [RL22]
		mu_sync_next = {mu_sync_reg[0], i_amplifier_mute_request}; // [RL22]
		sb_db_next = sb_db_reg;
		mu_db_next = mu_db_reg;
		sb_cnt_next = '0;
		mu_cnt_next = '0;
		// Level must hold DEBOUNCE_CYC cycles before it is accepted
		if (sb_sync_reg[1] != sb_db_reg) begin
			sb_cnt_next = sb_cnt_reg + `AMCS_CNT_W'(1);
			if (sb_cnt_reg >= DB_MAX - `AMCS_CNT_W'(1)) begin
				sb_db_next = sb_sync_reg[1]; // [RL22]
				sb_cnt_next = '0;
			end
		end
		if (mu_sync_reg[1] != mu_db_reg) begin
			mu_cnt_next = mu_cnt_reg + `AMCS_CNT_W'(1);
			if (mu_cnt_reg >= DB_MAX - `AMCS_CNT_W'(1)) begin
				mu_db_next = mu_sync_reg[1]; // [RL22]
				mu_cnt_next = '0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			sb_sync_reg <= 2'h0; // [RL2]
			mu_sync_reg <= 2'h0; // [RL7]
			sb_db_reg <= 1'h0;
			mu_db_reg <= 1'h0;
			sb_cnt_reg <= '0;
			mu_cnt_reg <= '0;
		end else begin
			sb_sync_reg <= sb_sync_next;
			mu_sync_reg <= mu_sync_next;
			sb_db_reg <= sb_db_next;
			mu_db_reg <= mu_db_next;
			sb_cnt_reg <= sb_cnt_next;
			mu_cnt_reg <= mu_cnt_next;
		end
	end

	// Sequencer
	amcs_pkg::amcs_state_type state_reg, state_next;
	logic [`AMCS_CNT_W-1:0] tmr_reg, tmr_next;
	logic aux_oc;
	logic amp_oc;

	// Primary side faults are deliberately not an input of this logic
	assign aux_oc = i_control_supply_oc | i_analog_supply_oc;
	assign amp_oc = i_amp_overcurrent;

	always_comb begin
		state_next = state_reg;
		tmr_next = '0;
		case (state_reg)
			amcs_pkg::AMCS_BOOT: begin
				// Self-checks must outlast the debounce time, or a
				// held standby request is seen one debounce late
				if (i_selfcheck_error) begin
					state_next = amcs_pkg::AMCS_REBOOT; // [RL21]
				end else if (i_selfcheck_done) begin
					if (sb_db_reg) begin
						state_next = amcs_pkg::AMCS_STANDBY; // [RL20]
					end else begin
						state_next = amcs_pkg::AMCS_RUN; // [RL20]
					end
				end
			end
			amcs_pkg::AMCS_REBOOT: begin
				tmr_next = tmr_reg + `AMCS_CNT_W'(1);
				if (tmr_reg >= RB_MAX - `AMCS_CNT_W'(1)) begin
					state_next = amcs_pkg::AMCS_BOOT; // [RL21]
					tmr_next = '0;
				end
			end
			amcs_pkg::AMCS_RUN, amcs_pkg::AMCS_STANDBY: begin
				// Faults outrank mode requests
				if (i_module_overtemp) begin
					state_next = amcs_pkg::AMCS_THERM_FAULT; // [RL12]
				end else if (aux_oc) begin
					state_next = amcs_pkg::AMCS_AUX_FAULT; // [RL17] [RL18]
				end else if (amp_oc && state_reg == amcs_pkg::AMCS_RUN) begin
					state_next = amcs_pkg::AMCS_AMP_FAULT; // [RL12]
				end else if (sb_db_reg) begin
					state_next = amcs_pkg::AMCS_STANDBY; // [RL1]
				end else begin
					state_next = amcs_pkg::AMCS_RUN;
				end
			end
			amcs_pkg::AMCS_AMP_FAULT, amcs_pkg::AMCS_AUX_FAULT: begin
				// Delay restarts only once the condition has gone
				if ((state_reg == amcs_pkg::AMCS_AUX_FAULT && aux_oc) ||
						(state_reg == amcs_pkg::AMCS_AMP_FAULT && amp_oc)) begin
					tmr_next = '0;
				end else begin
					tmr_next = tmr_reg + `AMCS_CNT_W'(1);
					if (tmr_reg >= RS_MAX - `AMCS_CNT_W'(1)) begin
						state_next = amcs_pkg::AMCS_RUN; // [RL14]
						tmr_next = '0;
					end
				end
			end
			amcs_pkg::AMCS_THERM_FAULT: begin
				if (i_module_overtemp || !i_thermal_recovered) begin
					tmr_next = '0; // [RL14]
				end else begin
					tmr_next = tmr_reg + `AMCS_CNT_W'(1);
					if (tmr_reg >= RS_MAX - `AMCS_CNT_W'(1)) begin
						state_next = amcs_pkg::AMCS_RUN; // [RL14]
						tmr_next = '0;
					end
				end
			end
			default: begin
				state_next = amcs_pkg::AMCS_BOOT;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_reg <= amcs_pkg::AMCS_BOOT;
			tmr_reg <= '0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
		end
	end

	// Output stage, all registered
	logic amp_en_reg, amp_en_next;
	logic ana_en_reg, ana_en_next;
	logic ctl_en_reg, ctl_en_next;
	logic ctl_lp_reg, ctl_lp_next;
	logic hng_en_reg, hng_en_next;
	logic clip_oe_reg, clip_oe_next;
	logic fault_oe_reg, fault_oe_next;
	logic in_fault;

	assign in_fault = state_next == amcs_pkg::AMCS_AMP_FAULT ||
		state_next == amcs_pkg::AMCS_AUX_FAULT ||
		state_next == amcs_pkg::AMCS_THERM_FAULT;

	always_comb begin
		amp_en_next = state_next == amcs_pkg::AMCS_RUN && !mu_db_reg; // [RL6]
		// Mute leaves all supplies as they are
		ana_en_next = state_next == amcs_pkg::AMCS_RUN; // [RL3] [RL8]
		ctl_en_next = state_next == amcs_pkg::AMCS_RUN ||
			state_next == amcs_pkg::AMCS_STANDBY ||
			state_next == amcs_pkg::AMCS_AMP_FAULT ||
			state_next == amcs_pkg::AMCS_THERM_FAULT; // [RL17] [RL18]
		ctl_lp_next = state_next == amcs_pkg::AMCS_STANDBY; // [RL3]
		hng_en_next = state_next == amcs_pkg::AMCS_RUN ||
			state_next == amcs_pkg::AMCS_STANDBY; // [RL19]
		// One low pulse per clipping PWM cycle; thermal warning holds it
		clip_oe_next = i_thermal_warning ||
			(i_pwm_cycle && i_clip_event); // [RL9] [RL10]
		fault_oe_next = in_fault; // [RL13] [RL15]
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			amp_en_reg <= 1'h0;
			ana_en_reg <= 1'h0;
			ctl_en_reg <= 1'h0;
			ctl_lp_reg <= 1'h0;
			hng_en_reg <= 1'h0;
			clip_oe_reg <= 1'h0;
			fault_oe_reg <= 1'h0;
		end else begin
			amp_en_reg <= amp_en_next;
			ana_en_reg <= ana_en_next;
			ctl_en_reg <= ctl_en_next;
			ctl_lp_reg <= ctl_lp_next;
			hng_en_reg <= hng_en_next;
			clip_oe_reg <= clip_oe_next;
			fault_oe_reg <= fault_oe_next;
		end
	end

	assign o_amp_enable = amp_en_reg;
	assign o_positive_analog_supply_en = ana_en_reg;
	assign o_negative_analog_supply_en = ana_en_reg;
	assign o_control_supply_out_en = ctl_en_reg;
	assign o_control_supply_low_power = ctl_lp_reg;
	assign o_hanger_rail_supply_en = hng_en_reg;
	assign o_clip_flag_out = 1'h0; // [RL11]
	assign o_clip_flag_oe = clip_oe_reg;
	assign o_fault_flag_out = 1'h0; // [RL16]
	assign o_fault_flag_oe = fault_oe_reg; // [RL12]
	assign o_state = state_reg;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence sb_seen_s;
		state_reg == amcs_pkg::AMCS_RUN && sb_db_reg && !i_module_overtemp
			&& !aux_oc && !amp_oc;
	endsequence

	standby_entry_a: assert property (sb_seen_s |=> state_reg == // [RL1]
		amcs_pkg::AMCS_STANDBY) else $error("standby not entered");
	standby_supply_a: assert property (state_reg == // [RL3]
		amcs_pkg::AMCS_STANDBY |-> !o_amp_enable &&
		!o_positive_analog_supply_en && o_control_supply_low_power)
		else $error("standby outputs wrong");
	mute_only_a: assert property (mu_db_reg && // [RL8]
		state_next == amcs_pkg::AMCS_RUN |=> !o_amp_enable &&
		o_positive_analog_supply_en && o_control_supply_out_en)
		else $error("mute touched supplies");
	clip_pulse_a: assert property (i_pwm_cycle && i_clip_event // [RL9]
		|=> o_clip_flag_oe) else $error("clip pulse missing");
	clip_release_a: assert property (!i_thermal_warning && // [RL10]
		!(i_pwm_cycle && i_clip_event) |=> !o_clip_flag_oe)
		else $error("clip flag not released");
	flags_low_a: assert property (o_clip_flag_out == 1'h0 && // [RL16]
		o_fault_flag_out == 1'h0) else $error("flag driven high");
	aux_cycle_a: assert property ($rose(state_reg == // [RL17]
		amcs_pkg::AMCS_AUX_FAULT) |-> !o_control_supply_out_en &&
		!o_positive_analog_supply_en && o_fault_flag_oe)
		else $error("aux supplies not cut");
	therm_hold_a: assert property (state_reg == // [RL14]
		amcs_pkg::AMCS_THERM_FAULT && !i_thermal_recovered |=>
		state_reg == amcs_pkg::AMCS_THERM_FAULT)
		else $error("thermal recovery ignored");
	hanger_on_a: assert property (state_reg == // [RL19]
		amcs_pkg::AMCS_STANDBY |-> o_hanger_rail_supply_en)
		else $error("hanger rail off in standby");

	// Causes are only acted on once the sequencer is operating
	sequence fault_cause_s;
		(state_reg == amcs_pkg::AMCS_RUN ||
			state_reg == amcs_pkg::AMCS_STANDBY) &&
			(i_module_overtemp || aux_oc ||
			(amp_oc && state_reg == amcs_pkg::AMCS_RUN));
	endsequence

	sequence oc_present_s;
		(state_reg == amcs_pkg::AMCS_AMP_FAULT && amp_oc) ||
			(state_reg == amcs_pkg::AMCS_AUX_FAULT && aux_oc);
	endsequence

	sequence boot_go_s;
		state_reg == amcs_pkg::AMCS_BOOT && !i_selfcheck_error &&
			i_selfcheck_done;
	endsequence

	fault_flag_a: assert property (fault_cause_s |=> // [RL12] [RL13]
		o_fault_flag_oe && !o_amp_enable)
		else $error("fault not flagged");
	primary_quiet_a: assert property (i_primary_fault && // [RL15]
		!in_fault |=> !o_fault_flag_oe)
		else $error("primary fault reported");
	oc_hold_a: assert property (oc_present_s |=> // [RL14]
		$stable(state_reg)) else $error("restart during overcurrent");
	reboot_entry_a: assert property (state_reg == // [RL21]
		amcs_pkg::AMCS_BOOT && i_selfcheck_error |=>
		state_reg == amcs_pkg::AMCS_REBOOT)
		else $error("self-check error not rebooted");
	boot_select_a: assert property (boot_go_s |=> state_reg == // [RL20]
		($past(sb_db_reg) ? amcs_pkg::AMCS_STANDBY : amcs_pkg::AMCS_RUN))
		else $error("boot picked wrong mode");
	mute_amp_a: assert property (mu_db_reg |=> !o_amp_enable) // [RL6]
		else $error("amplifier on while muted");
	db_hold_a: assert property (sb_sync_reg[1] == sb_db_reg && // [RL22]
		mu_sync_reg[1] == mu_db_reg |=> $stable(sb_db_reg) &&
		$stable(mu_db_reg)) else $error("debounced level moved");
endmodule

// *** sim/amcs_front_end.sv ***
// Front-end controller model: request drivers and status pull-ups
`timescale 1ns/10ps
module amcs_front_end #(
	parameter int HOLD_CYC = 20
) (
	input wire logic i_core_clk,
	input wire logic i_standby_cmd,
	input wire logic i_mute_cmd,
	input wire logic i_clip_flag_out,
	input wire logic i_clip_flag_oe,
	input wire logic i_fault_flag_out,
	input wire logic i_fault_flag_oe,
	output logic o_standby_request,
	output logic o_amplifier_mute_request,
	output logic o_clip_line,
	output logic o_fault_line
);
	int gap_reg = 0;
	initial o_standby_request = 1'h0;
	initial o_amplifier_mute_request = 1'h0;
	// Mode changes spaced, control load already lowered
	always @(negedge i_core_clk) begin
		o_amplifier_mute_request <= i_mute_cmd;
		if (gap_reg > 0) begin
			gap_reg <= gap_reg - 1;
		end else if (i_standby_cmd !== o_standby_request) begin
			o_standby_request <= i_standby_cmd;
			gap_reg <= HOLD_CYC;
		end
	end
	assign o_clip_line = i_clip_flag_oe ? i_clip_flag_out : 1'h1;
	assign o_fault_line = i_fault_flag_oe ? i_fault_flag_out : 1'h1;
endmodule

// *** sim/tb_amp_module_control_status.sv ***
// Testbench of the amplifier module control supervisor
`timescale 1ns/10ps
module tb_amp_module_control_status;
	logic clk = 1'h0, srst = 1'h1, sb_c = 1'h0, mu_c = 1'h0, dn = 1'h0;
	logic er = 1'h0, pwm = 1'h0, clp = 1'h0, tw = 1'h0, aoc = 1'h0;
	logic coc = 1'h0, noc = 1'h0, ot = 1'h0, rec = 1'h1, pf = 1'h0;
	logic sb, mu, amp, pos, neg, ctl, lp, hr, co, ce, fo, fe, cl, fl;
	amcs_pkg::amcs_state_type st;
	int failures = 0, num_checks = 0, cyc = 0;
	always #5 clk = ~clk;
	amcs_supervisor #(.DEBOUNCE_CYC(4), .RESTART_CYC(8), .REBOOT_CYC(8)) i_dut (
		.i_core_clk(clk), .i_srst(srst), .i_standby_request(sb),
		.i_amplifier_mute_request(mu), .i_selfcheck_done(dn),
		.i_selfcheck_error(er), .i_pwm_cycle(pwm), .i_clip_event(clp),
		.i_thermal_warning(tw), .i_amp_overcurrent(aoc),
		.i_control_supply_oc(coc), .i_analog_supply_oc(noc),
		.i_module_overtemp(ot), .i_thermal_recovered(rec),
		.i_primary_fault(pf), .o_amp_enable(amp),
		.o_positive_analog_supply_en(pos), .o_negative_analog_supply_en(neg),
		.o_control_supply_out_en(ctl), .o_control_supply_low_power(lp),
		.o_hanger_rail_supply_en(hr), .o_clip_flag_out(co),
		.o_clip_flag_oe(ce), .o_fault_flag_out(fo), .o_fault_flag_oe(fe),
		.o_state(st));
	amcs_front_end i_fe (.i_core_clk(clk), .i_standby_cmd(sb_c),
		.i_mute_cmd(mu_c), .i_clip_flag_out(co), .i_clip_flag_oe(ce),
		.i_fault_flag_out(fo), .i_fault_flag_oe(fe), .o_standby_request(sb),
		.o_amplifier_mute_request(mu), .o_clip_line(cl), .o_fault_line(fl));
	task automatic chk(input string n, input logic [2:0] e,
		input logic [2:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wst(input amcs_pkg::amcs_state_type s, input int lim);
		int n = 0;
		while (st !== s && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("state", s, st);
	endtask
	task automatic outs(input logic a, input logic p, input logic c,
		input logic l);
		chk("amp", a, amp);
		chk("pos", p, pos);
		chk("neg", p, neg);
		chk("ctl", c, ctl);
		chk("lp", l, lp);
	endtask
	task automatic steps(input int n);
		repeat (n) @(negedge clk);
	endtask
	task results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	task t_boot;
		chk("state", amcs_pkg::AMCS_BOOT, st);
		er <= 1'h1;
		dn <= 1'h1;
		wst(amcs_pkg::AMCS_REBOOT, 4);
		er <= 1'h0;
		dn <= 1'h0;
		wst(amcs_pkg::AMCS_BOOT, 14);
		dn <= 1'h1;
		wst(amcs_pkg::AMCS_RUN, 16);
		outs(1'h1, 1'h1, 1'h1, 1'h0);
	endtask
	task t_standby;
		sb_c <= 1'h1;
		wst(amcs_pkg::AMCS_STANDBY, 40);
		outs(1'h0, 1'h0, 1'h1, 1'h1);
		chk("hr", 1'h1, hr);
		sb_c <= 1'h0;
		wst(amcs_pkg::AMCS_RUN, 40);
		outs(1'h1, 1'h1, 1'h1, 1'h0);
	endtask
	task t_mute;
		mu_c <= 1'h1;
		steps(2);
		mu_c <= 1'h0;
		steps(12);
		chk("amp", 1'h1, amp);
		mu_c <= 1'h1;
		steps(12);
		outs(1'h0, 1'h1, 1'h1, 1'h0);
		chk("hr", 1'h1, hr);
		mu_c <= 1'h0;
		steps(12);
	endtask
	task t_clip;
		pwm <= 1'h1;
		clp <= 1'h1;
		steps(1);
		chk("clip", 1'h0, cl);
		{pwm, clp} <= 2'h0;
		steps(1);
		chk("clip", 1'h1, cl);
		tw <= 1'h1;
		steps(3);
		chk("clip", 1'h0, cl);
		tw <= 1'h0;
		steps(2);
		chk("clip", 1'h1, cl);
	endtask
	task automatic t_fault(input int k);
		aoc <= (k == 0);
		coc <= (k == 1);
		noc <= (k == 2);
		wst(k == 0 ? amcs_pkg::AMCS_AMP_FAULT :
			amcs_pkg::AMCS_AUX_FAULT, 3);
		chk("flt", 1'h0, fl);
		chk("amp", 1'h0, amp);
		chk("pos", 1'h0, pos);
		chk("ctl", k == 0, ctl);
		{aoc, coc, noc} <= 3'h0;
		wst(amcs_pkg::AMCS_RUN, 16);
		chk("flt", 1'h1, fl);
		outs(1'h1, 1'h1, 1'h1, 1'h0);
	endtask
	task t_therm;
		ot <= 1'h1;
		rec <= 1'h0;
		wst(amcs_pkg::AMCS_THERM_FAULT, 3);
		chk("amp", 1'h0, amp);
		ot <= 1'h0;
		steps(20);
		chk("flt", 1'h0, fl);
		rec <= 1'h1;
		wst(amcs_pkg::AMCS_RUN, 16);
		pf <= 1'h1;
		steps(5);
		chk("flt", 1'h1, fl);
		chk("state", amcs_pkg::AMCS_RUN, st);
		pf <= 1'h0;
	endtask
	task t_reset;
		srst <= 1'h1;
		dn <= 1'h0;
		sb_c <= 1'h1;
		steps(2);
		chk("state", amcs_pkg::AMCS_BOOT, st);
		outs(1'h0, 1'h0, 1'h0, 1'h0);
		chk("hr", 1'h0, hr);
		chk("flt", 1'h1, fl);
		chk("clip", 1'h1, cl);
		srst <= 1'h0;
		steps(12);
		chk("state", amcs_pkg::AMCS_BOOT, st);
		dn <= 1'h1;
		wst(amcs_pkg::AMCS_STANDBY, 4);
		outs(1'h0, 1'h0, 1'h1, 1'h1);
		chk("hr", 1'h1, hr);
		sb_c <= 1'h0;
		wst(amcs_pkg::AMCS_RUN, 40);
	endtask
	initial begin
		steps(4);
		srst <= 1'h0;
		steps(1);
		t_boot();
		t_standby();
		t_mute();
		t_clip();
		for (int k = 0; k < 3; k++) begin
			t_fault(k);
		end
		t_therm();
		t_reset();
		results();
	end
endmodule
